/* design/scan_pkg.sv */
// Shared constants and types for the boundary-scan test port and its tester.
package scan_pkg;
	// System clock and the link clock made by the tester.
	localparam int CLK_PERIOD_NS = 40;
	localparam int TCK_PERIOD_NS = 320;
	localparam int TCK_HALF_CYC  = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

	// Chain geometry: one state cell and one direction cell per pin.
	localparam int NUM_PINS     = 100;
	localparam int CHAIN_LEN    = 200;
	localparam int CELL_STATE   = 0;
	localparam int CELL_DIR     = 1;
	localparam int CELLS_PER_PIN = 2;

	// Pin slots at the TDO end of the chain; cell = 2 * slot.
	localparam int PIN_DATA_LINE_31 = 0, PIN_ADDRESS_LINE_12 = 1;
	localparam int PIN_ADDRESS_LINE_17 = 6, PIN_CLOCK_OUTPUT = 7;
	localparam int PIN_ADDRESS_LINE_18 = 8, PIN_ADDRESS_LINE_19 = 9;
	localparam int PIN_RESET_OUTPUT = 10, PIN_ADDRESS_LINE_20 = 11;
	localparam int PIN_RESET_INPUT = 12, PIN_ADDRESS_LINE_21 = 13;
	localparam int PIN_ADDRESS_LINE_22 = 14, PIN_TRANSFER_ERROR_ACK = 15;
	localparam int PIN_BYTE_ENABLE_0 = 16;

	// Instruction codes and capture values.
	localparam int         IR_W          = 4;
	localparam logic [3:0] IR_EXTEST     = 4'h0;
	localparam logic [3:0] IR_IDENT      = 4'h1;
	localparam logic [3:0] IR_SAMPLE     = 4'h2;
	localparam logic [3:0] IR_HIGHZ      = 4'h9;
	localparam logic [3:0] IR_CLAMP      = 4'hC;
	localparam logic [3:0] IR_BYPASS     = 4'hF;
	localparam logic [3:0] IR_RESET_VAL  = IR_IDENT;
	localparam logic [3:0] IR_CAPTURE    = 4'h1;
	localparam logic       BYPASS_CAPTURE = 1'b0;

	// Compliance straps held by the tester.
	localparam logic TEST_SELECT_LEVEL     = 1'b0;
	localparam logic COMPLIANCE_HOLD_LEVEL = 1'b1;

	// Tester word: {ir, last, bit}, and its mode-select sequences, LSB first.
	localparam int         WORD_W        = 3;
	localparam int         WORD_BIT      = 0;
	localparam int         WORD_LAST     = 1;
	localparam int         WORD_IR       = 2;
	localparam int         FIFO_DEPTH    = 16;
	localparam logic [5:0] SEQ_RESET     = 6'h1F;
	localparam logic [2:0] SEQ_RESET_LEN = 3'h6;
	localparam logic [5:0] SEQ_DR_HEAD   = 6'h01;
	localparam logic [2:0] SEQ_DR_LEN    = 3'h3;
	localparam logic [5:0] SEQ_IR_HEAD   = 6'h03;
	localparam logic [2:0] SEQ_IR_LEN    = 3'h4;
	localparam logic [5:0] SEQ_TAIL      = 6'h01;
	localparam logic [2:0] SEQ_TAIL_LEN  = 3'h2;

	// Test state machine states.
	typedef enum logic [15:0] {
		TAP_RESET  = 16'h0001, TAP_IDLE   = 16'h0002,
		TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
		TAP_SH_DR  = 16'h0010, TAP_EX1_DR = 16'h0020,
		TAP_PAU_DR = 16'h0040, TAP_EX2_DR = 16'h0080,
		TAP_UPD_DR = 16'h0100, TAP_SEL_IR = 16'h0200,
		TAP_CAP_IR = 16'h0400, TAP_SH_IR  = 16'h0800,
		TAP_EX1_IR = 16'h1000, TAP_PAU_IR = 16'h2000,
		TAP_EX2_IR = 16'h4000, TAP_UPD_IR = 16'h8000
	} tap_t;
endpackage

/* design/scan_link_if.sv */
// Test port link between the scanned device and the board tester.
`timescale 1ns/100ps
interface scan_link_if;
	logic test_port_clock;
	logic test_mode_sel;
	logic test_data_in;
	logic test_reset_n;
	logic test_data_out;
	logic test_data_out_oe_n;
	logic test_data_out_wire;
	logic test_select_pin;
	logic compliance_hold_pin;

	// The output line idles high through its pull-up when not driven.
	assign test_data_out_wire = test_data_out_oe_n ? 1'b1 : test_data_out;

	modport dev (
		input  test_port_clock, test_mode_sel, test_data_in, test_reset_n,
		input  test_select_pin, compliance_hold_pin,
		output test_data_out, test_data_out_oe_n
	);
	modport host (
		output test_port_clock, test_mode_sel, test_data_in, test_reset_n,
		output test_select_pin, compliance_hold_pin,
		input  test_data_out_wire
	);
endinterface

/* design/scan_port_dev.sv */
// Device end: bypass stage and boundary-scan chain behind the test port.
//
// Notes on behaviour
// - Bypass routes data through one stage.
// - Extest or sample selects the boundary chain.
// - Chain captures inputs, drives outputs and enables.
// - Chain holds exactly 200 cells.
// - Test clock may stop; no state lost.
// - Tester coordinates both clocks for mixed operation.
// - Low-power stop only in test-logic-reset.
// - Test clock never gated during stop.
// - Power-on reset forces test-logic-reset.
// - Test-logic-reset leaves functional logic untouched.
// - Tester holds select at 0, hold at 1.
// - Chain omits test, analog, supply, clock input pins.
// - Cell 0 sits next to the output.
// - State cell then direction cell, per pin.
// - State cells are non-inverting.
// - Direction 1 reads pin, 0 drives pin.
// - Cells 0 to 33 map the listed pins.
// - Tester never drives into driven nets.
// - Bypass captures 0 in capture-DR.
// - Sample captures pin and core values.
// - Update on falling edge; drive under extest/clamp.
// - Code 1111 selects bypass.
`timescale 1ns/100ps
module scan_port_dev #(
	parameter int NUM_PINS = scan_pkg::NUM_PINS
) (
	// Clock, reset and freeze
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic                clk_en,
	// Test port link
	scan_link_if.dev                 link,
	// Pad side
	input  wire logic [NUM_PINS-1:0] pin_level,
	output var  logic [NUM_PINS-1:0] pin_drive,
	output var  logic [NUM_PINS-1:0] pin_drive_oe_n,
	// Core side
	input  wire logic [NUM_PINS-1:0] core_out,
	input  wire logic [NUM_PINS-1:0] core_oe_n,
	input  wire logic                stop_req,
	output var  logic                core_reset,
	output var  logic                low_power_stop,
	output var  logic                scan_compliant,
	output var  scan_pkg::tap_t      tap_state
);
	import scan_pkg::*;

	localparam int CL = CELLS_PER_PIN * NUM_PINS;

	typedef struct packed {
		logic                tck_m, tck_s, tck_d;
		logic                tms_m, tms_s;
		logic                tdi_m, tdi_s;
		logic                rstn_m, rstn_s;
		logic                sel_m, sel_s, hold_m, hold_s;
		logic [NUM_PINS-1:0] pin_m, pin_s;
		tap_t                tap;
		logic [IR_W-1:0]     ir_sh, ir;
		logic                byp;
		logic [CL-1:0]       chain, upd;
		logic                tdo, tdo_oe_n;
		logic [NUM_PINS-1:0] drv, drv_oe_n;
		logic                core_rst, stop, compliant;
	} dev_state_t;

	dev_state_t          s_ff;
	dev_state_t          nxt_s;
	logic                rise, fall, in_tlr;
	logic                ext, samp, bsr_sel, hiz, clamp, drive_bsr;
	logic [CL-1:0]       cap;
	logic [NUM_PINS-1:0] drv_w, drv_oe_n_w;

	// Standard next-state function of the test state machine.
	function automatic tap_t tap_next(input tap_t st, input logic m);
		tap_next = TAP_RESET;
		unique case (st)
			TAP_RESET:  tap_next = m ? TAP_RESET  : TAP_IDLE;
			TAP_IDLE:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: tap_next = m ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = m ? TAP_RESET  : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: tap_next = m ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
		endcase
	endfunction

	// Link clock edges come from the synchronised copy only; the clock is
	// never gated, so edges keep arriving during stop.
	assign rise   = s_ff.tck_s & ~s_ff.tck_d;
	assign fall   = ~s_ff.tck_s & s_ff.tck_d;
	assign in_tlr = (s_ff.tap == TAP_RESET);

	// Instruction decode; nothing is selected while in test-logic-reset.
	assign ext       = (s_ff.ir == IR_EXTEST) & ~in_tlr;
	assign samp      = (s_ff.ir == IR_SAMPLE) & ~in_tlr;
	assign hiz       = (s_ff.ir == IR_HIGHZ) & ~in_tlr;
	assign clamp     = (s_ff.ir == IR_CLAMP) & ~in_tlr;
	assign bsr_sel   = ext | samp;
	assign drive_bsr = ext | clamp;

	// Per-pin cells: even cell is the pin's state, odd cell its direction.
	// Only scanned signal pins are listed; test, supply and clock input pins
	// never appear here.
	for (genvar k = 0; k < NUM_PINS; k++) begin : g_pin
		// Outputs are sampled ahead of the pad except under extest; inputs at the pad.
		assign cap[CELLS_PER_PIN*k+CELL_STATE] = (ext | core_oe_n[k]) ?
			s_ff.pin_s[k] : core_out[k];
		assign cap[CELLS_PER_PIN*k+CELL_DIR] = core_oe_n[k];
		// A state cell of 1 drives high; a direction cell of 0 drives.
		assign drv_w[k] = drive_bsr ?
			s_ff.upd[CELLS_PER_PIN*k+CELL_STATE] : core_out[k];
		assign drv_oe_n_w[k] = hiz ? 1'b1 : drive_bsr ?
			s_ff.upd[CELLS_PER_PIN*k+CELL_DIR] : core_oe_n[k];
	end

	// Next state: synchronisers, test state machine, shift stages, pads.
	always_comb begin
		nxt_s = s_ff;
		nxt_s.tck_m  = link.test_port_clock;
		nxt_s.tck_s  = s_ff.tck_m;
		nxt_s.tck_d  = s_ff.tck_s;
		nxt_s.tms_m  = link.test_mode_sel;
		nxt_s.tms_s  = s_ff.tms_m;
		nxt_s.tdi_m  = link.test_data_in;
		nxt_s.tdi_s  = s_ff.tdi_m;
		nxt_s.rstn_m = link.test_reset_n;
		nxt_s.rstn_s = s_ff.rstn_m;
		nxt_s.sel_m  = link.test_select_pin;
		nxt_s.sel_s  = s_ff.sel_m;
		nxt_s.hold_m = link.compliance_hold_pin;
		nxt_s.hold_s = s_ff.hold_m;
		nxt_s.pin_m  = pin_level;
		nxt_s.pin_s  = s_ff.pin_m;
		if (rise) begin
			if (s_ff.tap == TAP_CAP_DR) begin
				nxt_s.byp = BYPASS_CAPTURE;
				if (bsr_sel) begin
					nxt_s.chain = cap;
				end
			end
			if (s_ff.tap == TAP_SH_DR) begin
				nxt_s.byp = s_ff.tdi_s;
				if (bsr_sel) begin
					nxt_s.chain = {s_ff.tdi_s, s_ff.chain[CL-1:1]};
				end
			end
			if (s_ff.tap == TAP_CAP_IR) begin
				nxt_s.ir_sh = IR_CAPTURE;
			end
			if (s_ff.tap == TAP_SH_IR) begin
				nxt_s.ir_sh = {s_ff.tdi_s, s_ff.ir_sh[IR_W-1:1]};
			end
			nxt_s.tap = tap_next(s_ff.tap, s_ff.tms_s);
		end
		if (fall) begin
			// Cell 0 is nearest the output and leaves first.
			nxt_s.tdo_oe_n = 1'b1;
			if (s_ff.tap == TAP_SH_DR) begin
				nxt_s.tdo      = bsr_sel ? s_ff.chain[0] : s_ff.byp;
				nxt_s.tdo_oe_n = 1'b0;
			end else if (s_ff.tap == TAP_SH_IR) begin
				nxt_s.tdo      = s_ff.ir_sh[0];
				nxt_s.tdo_oe_n = 1'b0;
			end
			if (s_ff.tap == TAP_UPD_IR) begin
				nxt_s.ir = s_ff.ir_sh;
			end
			if (s_ff.tap == TAP_UPD_DR && bsr_sel) begin
				nxt_s.upd = s_ff.chain;
			end
		end
		// The test reset pin overrides any edge seen in the same cycle.
		if (!s_ff.rstn_s) begin
			nxt_s.tap = TAP_RESET;
		end
		if (in_tlr) begin
			nxt_s.ir = IR_RESET_VAL;
		end
		nxt_s.drv       = drv_w;
		nxt_s.drv_oe_n  = drv_oe_n_w;
		nxt_s.core_rst  = hiz | clamp;
		nxt_s.stop      = stop_req & in_tlr;
		nxt_s.compliant = (s_ff.sel_s == TEST_SELECT_LEVEL) &
			(s_ff.hold_s == COMPLIANCE_HOLD_LEVEL);
	end

	// State register; clk_en low freezes everything, and a frozen or
	// stopped link clock simply produces no edges.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_ff          <= '0;
			s_ff.tap      <= TAP_RESET;
			s_ff.ir       <= IR_RESET_VAL;
			s_ff.tdo_oe_n <= 1'b1;
			s_ff.drv_oe_n <= '1;
			// The test reset pin idles high; a low synchroniser would
			// look like a spurious test reset just after release.
			s_ff.rstn_m   <= 1'b1;
			s_ff.rstn_s   <= 1'b1;
		end else if (clk_en) begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from the state register.
	assign link.test_data_out      = s_ff.tdo;
	assign link.test_data_out_oe_n = s_ff.tdo_oe_n;
	assign pin_drive               = s_ff.drv;
	assign pin_drive_oe_n          = s_ff.drv_oe_n;
	assign core_reset              = s_ff.core_rst;
	assign low_power_stop          = s_ff.stop;
	assign scan_compliant          = s_ff.compliant;
	assign tap_state               = s_ff.tap;
endmodule

/* design/scan_host.sv */
// Tester end: word FIFO and the test-port sequencer that clocks it out.
`timescale 1ns/100ps
module scan_fifo #(
	parameter int WIDTH = scan_pkg::WORD_W,
	parameter int DEPTH = scan_pkg::FIFO_DEPTH
) (
	// Clock, reset and freeze
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             clk_en,
	// Filling side
	input  wire logic             in_valid,
	output var  logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output var  logic             out_valid,
	input  wire logic             out_ready,
	output var  logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr, rd;
		logic [AW:0]                 cnt;
		logic                        not_full, not_empty;
	} fifo_state_t;

	fifo_state_t s_ff;
	fifo_state_t nxt_s;
	logic        push, pop;

	// Depth must be a power of two so the pointers wrap by themselves.
	always_comb begin
		nxt_s = s_ff;
		push  = in_valid & s_ff.not_full;
		pop   = out_ready & s_ff.not_empty;
		if (push) begin
			nxt_s.mem[s_ff.wr] = in_data;
			nxt_s.wr           = s_ff.wr + AW'(1);
		end
		if (pop) begin
			nxt_s.rd = s_ff.rd + AW'(1);
		end
		if (push && !pop) begin
			nxt_s.cnt = s_ff.cnt + (AW+1)'(1);
		end else if (pop && !push) begin
			nxt_s.cnt = s_ff.cnt - (AW+1)'(1);
		end
		nxt_s.not_full  = (nxt_s.cnt != (AW+1)'(DEPTH));
		nxt_s.not_empty = (nxt_s.cnt != '0);
	end

	// Flags are registered so the ready seen by the source is a flop.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_ff          <= '0;
			s_ff.not_full <= 1'b1;
		end else if (clk_en) begin
			s_ff <= nxt_s;
		end
	end

	assign in_ready  = s_ff.not_full;
	assign out_valid = s_ff.not_empty;
	assign out_data  = s_ff.mem[s_ff.rd];
endmodule

module scan_host #(
	parameter int HALF_CYC = scan_pkg::TCK_HALF_CYC
) (
	// Clock, reset and freeze
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	input  wire logic                        clk_en,
	// Test port link
	scan_link_if.host                        link,
	// Word stream in: {ir, last, bit}
	input  wire logic                        word_valid,
	output var  logic                        word_ready,
	input  wire logic [scan_pkg::WORD_W-1:0] word_data,
	// Bits shifted out of the device
	output var  logic                        rx_valid,
	output var  logic                        rx_bit,
	// Test control
	input  wire logic                        park_req,
	input  wire logic                        test_reset_req
);
	import scan_pkg::*;

	localparam int CW = $clog2(HALF_CYC + 1);

	typedef enum logic [2:0] {
		H_SEQ   = 3'h1,
		H_IDLE  = 3'h2,
		H_SHIFT = 3'h4
	} host_st_t;

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tck, tms, tdi, trst_n;
		logic          tdo_m, tdo_s;
		host_st_t      st, after;
		logic [5:0]    seq;
		logic [2:0]    seq_n;
		logic          pend, rx_valid, rx_bit;
		logic          sel, hold;
	} host_state_t;

	host_state_t         s_ff;
	host_state_t         nxt_s;
	logic                f_valid, f_pop, at_end, stall, tick, go_low;
	logic [WORD_W-1:0]   f_word;

	scan_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.clk_en    (clk_en),
		.in_valid  (word_valid),
		.in_ready  (word_ready),
		.in_data   (word_data),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (f_word)
	);

	// The device logic is static, so the clock may be held high while a
	// scan waits for data instead of shifting filler bits.
	assign at_end = (s_ff.cnt == CW'(HALF_CYC - 1));
	assign stall  = s_ff.tck & (s_ff.st == H_SHIFT) & ~f_valid;
	assign tick   = at_end & ~stall;
	assign go_low = tick & s_ff.tck;
	assign f_pop  = go_low & (s_ff.st == H_SHIFT);

	// Sequencer: mode-select and data change only as the clock falls.
	always_comb begin
		nxt_s          = s_ff;
		nxt_s.tdo_m    = link.test_data_out_wire;
		nxt_s.tdo_s    = s_ff.tdo_m;
		nxt_s.rx_valid = 1'b0;
		nxt_s.trst_n   = ~test_reset_req;
		nxt_s.sel      = TEST_SELECT_LEVEL;
		nxt_s.hold     = COMPLIANCE_HOLD_LEVEL;
		nxt_s.cnt      = tick ? '0 : at_end ? s_ff.cnt : s_ff.cnt + CW'(1);
		if (tick) begin
			nxt_s.tck = ~s_ff.tck;
		end
		if (go_low) begin
			// Output data is read at the end of the high phase, after the
			// device's synchronised view of the last fall has settled.
			if (s_ff.pend) begin
				nxt_s.rx_valid = 1'b1;
				nxt_s.rx_bit   = s_ff.tdo_s;
				nxt_s.pend     = 1'b0;
			end
			unique case (s_ff.st)
				H_SEQ: begin
					nxt_s.tms   = s_ff.seq[0];
					nxt_s.seq   = {1'b0, s_ff.seq[5:1]};
					nxt_s.seq_n = s_ff.seq_n - 3'h1;
					if (s_ff.seq_n == 3'h1) begin
						nxt_s.st = s_ff.after;
					end
				end
				H_IDLE: begin
					// Parking in test-logic-reset lets the device stop.
					nxt_s.tms = park_req & ~f_valid;
					if (f_valid) begin
						nxt_s.st    = H_SEQ;
						nxt_s.after = H_SHIFT;
						nxt_s.seq   = f_word[WORD_IR] ? SEQ_IR_HEAD : SEQ_DR_HEAD;
						nxt_s.seq_n = f_word[WORD_IR] ? SEQ_IR_LEN : SEQ_DR_LEN;
					end
				end
				H_SHIFT: begin
					nxt_s.tdi  = f_word[WORD_BIT];
					nxt_s.tms  = f_word[WORD_LAST];
					nxt_s.pend = 1'b1;
					if (f_word[WORD_LAST]) begin
						nxt_s.st    = H_SEQ;
						nxt_s.after = H_IDLE;
						nxt_s.seq   = SEQ_TAIL;
						nxt_s.seq_n = SEQ_TAIL_LEN;
					end
				end
			endcase
		end
	end

	// Reset walks the device into test-logic-reset, then to idle.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_ff        <= '0;
			s_ff.st     <= H_SEQ;
			s_ff.after  <= H_IDLE;
			s_ff.seq    <= SEQ_RESET;
			s_ff.seq_n  <= SEQ_RESET_LEN;
			s_ff.tms    <= 1'b1;
			s_ff.trst_n <= 1'b1;
			s_ff.hold   <= COMPLIANCE_HOLD_LEVEL;
		end else if (clk_en) begin
			s_ff <= nxt_s;
		end
	end

	assign link.test_port_clock     = s_ff.tck;
	assign link.test_mode_sel       = s_ff.tms;
	assign link.test_data_in        = s_ff.tdi;
	assign link.test_reset_n        = s_ff.trst_n;
	assign link.test_select_pin     = s_ff.sel;
	assign link.compliance_hold_pin = s_ff.hold;
	assign rx_valid                 = s_ff.rx_valid;
	assign rx_bit                   = s_ff.rx_bit;
endmodule

/* bench/scan_link_props.sv */
// Concurrent checks on the test port link joining the two ends.
`timescale 1ns/100ps
module scan_link_props (
	// Clock and reset
	input wire logic	clk_sys,
	input wire logic	rst,
	// Link signals
	input wire logic	test_port_clock,
	input wire logic	test_mode_sel,
	input wire logic	test_data_in,
	input wire logic	test_reset_n,
	input wire logic	test_data_out,
	input wire logic	test_data_out_oe_n,
	input wire logic	test_data_out_wire,
	input wire logic	test_select_pin,
	input wire logic	compliance_hold_pin
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// The device answers only in the low phase, after a falling edge.
	property p_tdo_low;
		$changed(test_data_out) |-> !test_port_clock;
	endproperty
	a_tdo_low: assert property (p_tdo_low)
		else $error("Serial output moved in the high phase.");
	property p_oe_low;
		$fell(test_data_out_oe_n) |-> !test_port_clock;
	endproperty
	a_oe_low: assert property (p_oe_low)
		else $error("Output enable switched in the high phase.");
	// The resolved line, release included, only moves in the low phase.
	property p_line_low;
		$changed(test_data_out_wire) |-> !test_port_clock;
	endproperty
	a_line_low: assert property (p_line_low)
		else $error("Serial output line moved in the high phase.");

	// The tester holds mode and data steady across the rising edge.
	property p_tms_hold;
		test_port_clock |-> $stable(test_mode_sel);
	endproperty
	a_tms_hold: assert property (p_tms_hold)
		else $error("Mode select moved while the clock was high.");
	property p_tdi_hold;
		test_port_clock |-> $stable(test_data_in);
	endproperty
	a_tdi_hold: assert property (p_tdi_hold)
		else $error("Serial input moved while the clock was high.");

	// Each link clock phase spans at least three system clocks, so the
	// device's synchronisers always see it.
	property p_high_min;
		$rose(test_port_clock) |-> test_port_clock[*3];
	endproperty
	a_high_min: assert property (p_high_min)
		else $error("Link clock high phase too short.");
	property p_low_min;
		$fell(test_port_clock) |-> (!test_port_clock)[*3];
	endproperty
	a_low_min: assert property (p_low_min)
		else $error("Link clock low phase too short.");

	// Out of reset the line is quiet and the tester walks to reset state.
	property p_reset_state;
		$fell(rst) |-> test_data_out_oe_n && !test_data_out && test_reset_n;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("Link not quiet after reset.");
	property p_park_ones;
		$fell(rst) |-> test_mode_sel[*8];
	endproperty
	a_park_ones: assert property (p_park_ones)
		else $error("Mode select not held high after reset.");

	// Compliance straps never leave their levels.
	property p_straps;
		compliance_hold_pin && !test_select_pin;
	endproperty
	a_straps: assert property (p_straps)
		else $error("Compliance straps at wrong levels.");
endmodule

/* bench/tb_boundary_scan_bypass_path.sv */
// Self-checking bench for the device and tester ends joined over the link.
`timescale 1ns/100ps
module tb_boundary_scan_bypass_path;
	import scan_pkg::*;
	// The preload enables only even pads, nets the board leaves undriven.
	localparam logic [255:0] PRELOAD = {64{4'h9}};
	logic			clk_sys, rst, stop_req, park_req, test_reset_req;
	logic [NUM_PINS-1:0]	pin_level, core_out, core_oe_n;
	logic [NUM_PINS-1:0]	pin_drive, pin_drive_oe_n;
	logic			core_reset, low_power_stop, scan_compliant;
	logic			bad_compliant, saw_full;
	logic			word_valid, word_ready, rx_valid, rx_bit;
	logic [WORD_W-1:0]	word_data;
	tap_t			tap_state;
	logic			q[$];
	int			failures = 0, tests_run = 0, cycles = 0;

	scan_link_if link ();
	scan_link_if link_bad ();

	// Device end under test, pads fed from the bench.
	scan_port_dev scan_port_dev_inst (
		.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .link(link.dev),
		.pin_level(pin_level), .pin_drive(pin_drive),
		.pin_drive_oe_n(pin_drive_oe_n), .core_out(core_out),
		.core_oe_n(core_oe_n), .stop_req(stop_req), .core_reset(core_reset),
		.low_power_stop(low_power_stop), .scan_compliant(scan_compliant),
		.tap_state(tap_state));
	// Second device whose straps are held wrong on purpose.
	scan_port_dev scan_port_dev_inst_2 (
		.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .link(link_bad.dev),
		.pin_level(pin_level), .pin_drive(), .pin_drive_oe_n(),
		.core_out(core_out), .core_oe_n(core_oe_n), .stop_req(stop_req),
		.core_reset(), .low_power_stop(), .scan_compliant(bad_compliant),
		.tap_state());
	assign link_bad.test_port_clock = 1'b0;
	assign link_bad.test_mode_sel = 1'b1;
	assign link_bad.test_data_in = 1'b1;
	assign link_bad.test_reset_n = 1'b1;
	assign link_bad.test_select_pin = 1'b1;
	assign link_bad.compliance_hold_pin = 1'b0;
	// Tester end that clocks words out over the link.
	scan_host scan_host_inst (
		.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .link(link.host),
		.word_valid(word_valid), .word_ready(word_ready),
		.word_data(word_data), .rx_valid(rx_valid), .rx_bit(rx_bit),
		.park_req(park_req), .test_reset_req(test_reset_req));
	// Link checker beside the joined interface.
	scan_link_props scan_link_props_inst (
		.clk_sys(clk_sys), .rst(rst),
		.test_port_clock(link.test_port_clock),
		.test_mode_sel(link.test_mode_sel),
		.test_data_in(link.test_data_in),
		.test_reset_n(link.test_reset_n),
		.test_data_out(link.test_data_out),
		.test_data_out_oe_n(link.test_data_out_oe_n),
		.test_data_out_wire(link.test_data_out_wire),
		.test_select_pin(link.test_select_pin),
		.compliance_hold_pin(link.compliance_hold_pin));

	// System clock.
	initial begin
		clk_sys = 1'b0;
		forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
	end
	// Returned bits are taken at the falling edge, clear of the launch.
	always @(negedge clk_sys) begin
		if (rx_valid === 1'b1) q.push_back(rx_bit);
		if (word_ready === 1'b0) saw_full = 1'b1;
	end
	// A hung handshake ends the run as a failure.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	task automatic check(input logic [255:0] seen, input logic [255:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (failures == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic wait_state(input tap_t s);
		for (int i = 0; i < 5000 && tap_state !== s; i++) @(negedge clk_sys);
	endtask

	// One word per handshake; valid drops for a cycle between words.
	task automatic push(input logic [WORD_W-1:0] w);
		@(posedge clk_sys);
		word_valid <= 1'b1;
		word_data <= w;
		@(negedge clk_sys);
		while (word_ready !== 1'b1) @(negedge clk_sys);
		@(posedge clk_sys);
		word_valid <= 1'b0;
	endtask

	// Shifts n bits LSB first; may starve the FIFO mid-frame at word stall.
	task automatic scan(input logic ir, input int n, input int stall,
			input logic [255:0] din, output logic [255:0] dout);
		q.delete();
		for (int i = 0; i < n; i++) begin
			if (i == stall) repeat (200) @(posedge clk_sys);
			push({ir, i == n - 1, din[i]});
		end
		for (int i = 0; i < 8000 && q.size() < n; i++) @(negedge clk_sys);
		dout = '0;
		foreach (q[i]) dout[i] = q[i];
		wait_state(TAP_IDLE);
	endtask

	task automatic set_ir(input logic [3:0] code);
		logic [255:0] r;
		scan(1'b1, 4, -1, code, r);
		repeat (4) @(negedge clk_sys);
	endtask

	// Power-up leaves the port in reset state and transparent.
	task automatic t_reset();
		repeat (5) @(negedge clk_sys);
		check(tap_state, TAP_RESET);
		check(low_power_stop, 1'b1);
		check({pin_drive, pin_drive_oe_n}, {core_out, core_oe_n});
		check({scan_compliant, bad_compliant}, 2'h2);
	endtask

	// Bypass and the codes that fall back to it give a one-stage path.
	task automatic t_bypass();
		logic [3:0] codes [3];
		logic [255:0] r;
		codes = '{IR_BYPASS, IR_IDENT, 4'h7};
		foreach (codes[c]) begin
			set_ir(codes[c]);
			scan(1'b0, 9, -1, 9'h1B5, r);
			check(r[8:0], 9'h16A);
			check(low_power_stop, 1'b0);
		end
	endtask

	// Sample a full frame with a stall mid-frame, preloading the cells.
	task automatic t_sample();
		logic [255:0] r, e;
		int b = CELLS_PER_PIN * PIN_BYTE_ENABLE_0 + CELL_DIR;
		e = '0;
		saw_full = 1'b0;
		set_ir(IR_SAMPLE);
		scan(1'b0, 208, 100, PRELOAD, r);
		for (int k = 0; k < NUM_PINS; k++) begin
			e[2*k] = core_oe_n[k] ? pin_level[k] : core_out[k];
			e[2*k+1] = core_oe_n[k];
		end
		e[CHAIN_LEN+:8] = PRELOAD[7:0];
		check(r, e);
		check(saw_full, 1'b1);
		check(r[b], core_oe_n[PIN_BYTE_ENABLE_0]);
	endtask

	// Extest and clamp drive the preloaded cells; highz floats all pads.
	task automatic t_drive();
		logic [2*NUM_PINS-1:0] pads;
		pads = {{25{4'h5}}, {25{4'hA}}};
		set_ir(IR_EXTEST);
		check({pin_drive, pin_drive_oe_n}, pads);
		set_ir(IR_CLAMP);
		check({core_reset, pin_drive, pin_drive_oe_n}, {1'b1, pads});
		set_ir(IR_HIGHZ);
		check({core_reset, pin_drive_oe_n}, {1'b1, {NUM_PINS{1'b1}}});
		set_ir(IR_SAMPLE);
		check({pin_drive, pin_drive_oe_n}, {core_out, core_oe_n});
	endtask

	// Parking returns pads to the core; the test reset pin also resets.
	task automatic t_park();
		@(posedge clk_sys);
		park_req <= 1'b1;
		core_out <= ~core_out;
		wait_state(TAP_RESET);
		repeat (3) @(negedge clk_sys);
		check(tap_state, TAP_RESET);
		check({low_power_stop, core_reset}, 2'h2);
		check({pin_drive, pin_drive_oe_n}, {core_out, core_oe_n});
		@(posedge clk_sys);
		park_req <= 1'b0;
		wait_state(TAP_IDLE);
		@(posedge clk_sys);
		test_reset_req <= 1'b1;
		wait_state(TAP_RESET);
		check(tap_state, TAP_RESET);
		@(posedge clk_sys);
		test_reset_req <= 1'b0;
	endtask

	// Main sequence: reset held for eight clocks, then the scenarios.
	initial begin
		rst = 1'b1;
		stop_req = 1'b1;
		park_req = 1'b0;
		test_reset_req = 1'b0;
		word_valid = 1'b0;
		word_data = '0;
		core_out = {25{4'h3}};
		core_oe_n = {25{4'hA}};
		pin_level = {25{4'hC}};
		saw_full = 1'b0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_bypass();
		t_sample();
		t_drive();
		t_park();
		print_verdict();
	end
endmodule
